//--- core/ssm_map.vh
// register offsets, field positions and reset values for the serial master
`ifndef SSM_MAP_VH
`define SSM_MAP_VH
// -----------------------------------------------------------------
// register byte offsets
// -----------------------------------------------------------------
`define SSM_TX_CTRL_OFS   8'h00
`define SSM_RX_CTRL_OFS   8'h04
`define SSM_DIVISOR_OFS   8'h08
`define SSM_HOLD_OFS      8'h0C
// -----------------------------------------------------------------
// transmit_control_reg fields
// -----------------------------------------------------------------
`define SSM_TX_CLKSRC_BIT 7
`define SSM_TX_NINE_BIT   6
`define SSM_TX_EN_BIT     5
`define SSM_TX_SYNC_BIT   4
`define SSM_TX_HSPD_BIT   2
`define SSM_TX_EMPTY_BIT  1
`define SSM_TX_D9_BIT     0
// -----------------------------------------------------------------
// receive_control_reg fields
// -----------------------------------------------------------------
`define SSM_RX_PORT_BIT   7
`define SSM_RX_SINGLE_BIT 5
`define SSM_RX_CONT_BIT   4
// -----------------------------------------------------------------
// reset values
// -----------------------------------------------------------------
`define SSM_TX_CTRL_RST   8'h02
`define SSM_RX_CTRL_RST   8'h00
`define SSM_DIVISOR_RST   8'h00
`endif

//--- core/ssm_baud_gen.v
// baud generator giving a one-cycle tick every divisor+1 system cycles
`timescale 1ns/1ps
module ssm_baud_gen #(
    parameter WIDTH = 8
) (
    input  wire             hclk,
    input  wire             hresetn,
    input  wire             run,
    input  wire [WIDTH-1:0] divisor,
    output reg              tick
);
    reg [WIDTH-1:0] count;

    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            count <= {WIDTH{1'b0}};
            tick  <= 1'b0;
        end
        else if (!run)
        begin
            // restart so the first half period after start is full length
            count <= {WIDTH{1'b0}};
            tick  <= 1'b0;
        end
        else if (count >= divisor)
        begin
            count <= {WIDTH{1'b0}};
            tick  <= 1'b1;
        end
        else
        begin
            count <= count + 1'b1;
            tick  <= 1'b0;
        end
    end
endmodule

//--- core/ssm_top.v
// synchronous serial master transmitter with ahb-lite register slave
`timescale 1ns/1ps
`include "ssm_map.vh"
module ssm_top #(
    parameter DIV_WIDTH = 8
) (
    input  wire        hclk,
    input  wire        hresetn,
    input  wire        hsel,
    input  wire [7:0]  haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output wire [31:0] hrdata,
    output wire        hreadyout,
    output wire        hresp,
    output reg         shift_clock_pin_o,
    output wire        shift_clock_pin_oe,
    input  wire        shift_clock_pin_i,
    output reg         serial_data_pin_o,
    output wire        serial_data_pin_oe,
    input  wire        serial_data_pin_i
);
    // -----------------------------------------------------------------
    // state codes
    // -----------------------------------------------------------------
    localparam ST_IDLE  = 2'd0;
    localparam ST_LOW   = 2'd1;
    localparam ST_HIGH  = 2'd2;

    // -----------------------------------------------------------------
    // registers
    // -----------------------------------------------------------------
    reg                 clock_source_master_sel;
    reg                 nine_bit_tx_sel;
    reg                 transmit_en;
    reg                 sync_mode_sel;
    reg                 baud_high_speed_sel;
    reg                 tx_ninth_bit;
    reg                 serial_port_en;
    reg                 single_receive_en;
    reg                 continuous_receive_en;
    reg [DIV_WIDTH-1:0] baud_divisor_reg;
    reg [7:0]           transmit_holding_reg;
    reg                 hold_full;
    reg                 hold_ninth;
    reg [8:0]           transmit_shift_reg;
    reg [3:0]           bits_left;
    reg [1:0]           state;
    reg                 wr_pend;
    reg                 rd_pend;
    reg [7:0]           addr_q;
    reg [31:0]          rdata_q;
    reg                 clk_sync1;
    reg                 clk_sync2;
    reg                 dat_sync1;
    reg                 dat_sync2;

    wire                tick;
    wire                hold_write;
    wire                port_on;
    wire                master_tx;
    wire                load_now;
    wire                tsr_empty;

    // -----------------------------------------------------------------
    // mode decode
    // -----------------------------------------------------------------
    assign port_on   = serial_port_en;
    assign master_tx = port_on & sync_mode_sel & clock_source_master_sel
                     & ~single_receive_en & ~continuous_receive_en;
    assign tsr_empty = (state == ST_IDLE);

    // pins are read back only through synchronisers; receive path is absent
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            clk_sync1 <= 1'b0;
            clk_sync2 <= 1'b0;
            dat_sync1 <= 1'b0;
            dat_sync2 <= 1'b0;
        end
        else
        begin
            clk_sync1 <= shift_clock_pin_i;
            clk_sync2 <= clk_sync1;
            dat_sync1 <= serial_data_pin_i;
            dat_sync2 <= dat_sync1;
        end
    end

    // -----------------------------------------------------------------
    // ahb-lite slave, zero wait states
    // -----------------------------------------------------------------
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = rdata_q;
    assign hold_write = wr_pend & (addr_q == `SSM_HOLD_OFS);

    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_pend <= 1'b0;
            rd_pend <= 1'b0;
            addr_q  <= 8'h00;
        end
        else if (hready)
        begin
            wr_pend <= hsel & htrans[1] & hwrite;
            rd_pend <= hsel & htrans[1] & ~hwrite;
            addr_q  <= haddr;
        end
        else
        begin
            wr_pend <= 1'b0;
            rd_pend <= 1'b0;
        end
    end

    // read data registered at the address phase so it stands in the data phase
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            rdata_q <= 32'h0000_0000;
        else if (hready & hsel & htrans[1] & ~hwrite)
        begin
            case (haddr)
                `SSM_TX_CTRL_OFS:
                    rdata_q <= {24'h00_0000, clock_source_master_sel, nine_bit_tx_sel,
                                transmit_en, sync_mode_sel, 1'b0, baud_high_speed_sel,
                                tsr_empty, tx_ninth_bit};
                `SSM_RX_CTRL_OFS:
                    rdata_q <= {24'h00_0000, serial_port_en, 1'b0, single_receive_en,
                                continuous_receive_en, 4'h0};
                `SSM_DIVISOR_OFS:
                    rdata_q <= {{(32-DIV_WIDTH){1'b0}}, baud_divisor_reg};
                `SSM_HOLD_OFS:
                    rdata_q <= {24'h00_0000, transmit_holding_reg};
                // shift register has no address; everything else reads zero
                default:
                    rdata_q <= 32'h0000_0000;
            endcase
        end
    end

    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            clock_source_master_sel <= 1'b0;
            nine_bit_tx_sel         <= 1'b0;
            transmit_en             <= 1'b0;
            sync_mode_sel           <= 1'b0;
            baud_high_speed_sel     <= 1'b0;
            tx_ninth_bit            <= 1'b0;
            serial_port_en          <= 1'b0;
            single_receive_en       <= 1'b0;
            continuous_receive_en   <= 1'b0;
            baud_divisor_reg        <= {DIV_WIDTH{1'b0}};
        end
        else if (wr_pend)
        begin
            case (addr_q)
                `SSM_TX_CTRL_OFS:
                begin
                    clock_source_master_sel <= hwdata[`SSM_TX_CLKSRC_BIT];
                    nine_bit_tx_sel         <= hwdata[`SSM_TX_NINE_BIT];
                    transmit_en             <= hwdata[`SSM_TX_EN_BIT];
                    sync_mode_sel           <= hwdata[`SSM_TX_SYNC_BIT];
                    baud_high_speed_sel     <= hwdata[`SSM_TX_HSPD_BIT];
                    tx_ninth_bit            <= hwdata[`SSM_TX_D9_BIT];
                end
                `SSM_RX_CTRL_OFS:
                begin
                    serial_port_en        <= hwdata[`SSM_RX_PORT_BIT];
                    single_receive_en     <= hwdata[`SSM_RX_SINGLE_BIT];
                    continuous_receive_en <= hwdata[`SSM_RX_CONT_BIT];
                end
                `SSM_DIVISOR_OFS:
                    baud_divisor_reg <= hwdata[DIV_WIDTH-1:0];
                default:
                    baud_divisor_reg <= baud_divisor_reg;
            endcase
        end
    end

    // -----------------------------------------------------------------
    // holding buffer
    // -----------------------------------------------------------------
    assign load_now = hold_full & tsr_empty & master_tx & transmit_en;

    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            transmit_holding_reg <= 8'h00;
            hold_full            <= 1'b0;
            hold_ninth           <= 1'b0;
        end
        else if (!port_on)
            hold_full <= 1'b0;
        else if (hold_write)
        begin
            // a write while already full overwrites the waiting character
            transmit_holding_reg <= hwdata[7:0];
            hold_ninth           <= tx_ninth_bit;
            hold_full            <= 1'b1;
        end
        else if (load_now)
            hold_full <= 1'b0;
    end

    // -----------------------------------------------------------------
    // baud generator: tick marks each half of the shift clock
    // -----------------------------------------------------------------
    ssm_baud_gen #(
        .WIDTH   (DIV_WIDTH)
    ) u_baud (
        .hclk    (hclk),
        .hresetn (hresetn),
        .run     (~tsr_empty & port_on),
        .divisor (baud_divisor_reg),
        .tick    (tick)
    );

    // -----------------------------------------------------------------
    // shifter; clock idles low, falling (trailing) edge puts out the bit
    // -----------------------------------------------------------------
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            state              <= ST_IDLE;
            transmit_shift_reg <= 9'h000;
            bits_left          <= 4'h0;
            shift_clock_pin_o  <= 1'b0;
            serial_data_pin_o  <= 1'b0;
        end
        else if (!port_on)
        begin
            state             <= ST_IDLE;
            bits_left         <= 4'h0;
            shift_clock_pin_o <= 1'b0;
        end
        else
        begin
            case (state)
                ST_IDLE:
                begin
                    shift_clock_pin_o <= 1'b0;
                    if (load_now)
                    begin
                        // first bit appears with the load, no framing bit
                        serial_data_pin_o  <= transmit_holding_reg[0];
                        transmit_shift_reg <= {1'b0, hold_ninth, transmit_holding_reg[7:1]};
                        bits_left          <= nine_bit_tx_sel ? 4'd9 : 4'd8;
                        state              <= ST_LOW;
                    end
                end
                ST_LOW:
                    if (tick)
                    begin
                        shift_clock_pin_o <= 1'b1;
                        bits_left         <= bits_left - 4'd1;
                        state             <= ST_HIGH;
                    end
                ST_HIGH:
                    if (tick)
                    begin
                        shift_clock_pin_o <= 1'b0;
                        if (bits_left == 4'd0)
                            state <= ST_IDLE;
                        else
                        begin
                            serial_data_pin_o  <= transmit_shift_reg[0];
                            transmit_shift_reg <= {1'b0, transmit_shift_reg[8:1]};
                            state              <= ST_LOW;
                        end
                    end
                default:
                    state <= ST_IDLE;
            endcase
        end
    end

    // -----------------------------------------------------------------
    // pin drivers
    // -----------------------------------------------------------------
    assign shift_clock_pin_oe = port_on & sync_mode_sel & clock_source_master_sel;
    // data pin released in receive directions so the line is never fought
    assign serial_data_pin_oe = master_tx;
endmodule

//--- tb/ssm_top_properties.sv
// concurrent checks on the serial master ports
`timescale 1ns/1ps
`include "ssm_map.vh"
module ssm_top_properties #(
    parameter DIV_WIDTH = 8
) (
    input wire        hclk,
    input wire        hresetn,
    input wire        hsel,
    input wire [7:0]  haddr,
    input wire [1:0]  htrans,
    input wire        hwrite,
    input wire [31:0] hwdata,
    input wire        hready,
    input wire [31:0] hrdata,
    input wire        shift_clock_pin_o,
    input wire        shift_clock_pin_oe,
    input wire        serial_data_pin_o,
    input wire        serial_data_pin_oe
);
    // ----
    // bus phase tracking and shift clock timing
    // ----
    reg        ph_wr;
    reg        ph_rd;
    reg [7:0]  ph_a;
    reg [15:0] div_q;
    reg [15:0] hi_cnt;
    wire       take = hsel & htrans[1] & hready;
    always @(posedge hclk or negedge hresetn)
        if (!hresetn)
        begin
            ph_wr  <= 1'b0;
            ph_rd  <= 1'b0;
            ph_a   <= 8'h00;
            div_q  <= 16'h0000;
            hi_cnt <= 16'h0000;
        end
        else
        begin
            ph_wr  <= take & hwrite;
            ph_rd  <= take & ~hwrite;
            if (take)
                ph_a <= haddr;
            if (ph_wr && ph_a == `SSM_DIVISOR_OFS)
                div_q <= {{(16-DIV_WIDTH){1'b0}}, hwdata[DIV_WIDTH-1:0]};
            hi_cnt <= shift_clock_pin_o ? hi_cnt + 16'h0001 : 16'h0000;
        end
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    // ----
    // assertions
    // ----
    a_data_needs_clock: assert property (
        serial_data_pin_oe |-> shift_clock_pin_oe) else $error("data driven without clock");
    a_clock_stops_off: assert property (
        $fell(shift_clock_pin_oe) |-> ##1 !shift_clock_pin_o) else $error("clock runs when off");
    a_data_stable_rise: assert property (
        $rose(shift_clock_pin_o) |-> $stable(serial_data_pin_o)) else $error("data moved at rise");
    a_bit_holds_high: assert property (
        shift_clock_pin_o && $past(shift_clock_pin_o) |-> $stable(serial_data_pin_o))
        else $error("data moved while clock high");
    a_high_time_div: assert property (
        $fell(shift_clock_pin_o) && shift_clock_pin_oe |-> hi_cnt == div_q + 16'h0001)
        else $error("clock high time wrong");
    a_rise_needs_drive: assert property (
        $rose(shift_clock_pin_o) |-> shift_clock_pin_oe) else $error("clock rose undriven");
    a_unmapped_zero: assert property (
        ph_rd && ph_a >= 8'h10 |-> hrdata == 32'h0000_0000) else $error("unmapped read not 0");
    a_read_upper_zero: assert property (
        ph_rd |-> hrdata[31:8] == 24'h00_0000) else $error("upper read bits set");
    c_clock_rise: cover property ($rose(shift_clock_pin_o));
    c_data_drive: cover property ($rose(serial_data_pin_oe));
    c_unmapped: cover property (ph_rd && ph_a >= 8'h10);
endmodule
bind ssm_top ssm_top_properties #(.DIV_WIDTH(DIV_WIDTH)) u_props (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .shift_clock_pin_o(shift_clock_pin_o), .shift_clock_pin_oe(shift_clock_pin_oe),
    .serial_data_pin_o(serial_data_pin_o), .serial_data_pin_oe(serial_data_pin_oe)
);

//--- tb/ssm_slave_model.sv
// slave receiver sharing the shift clock and data line
`timescale 1ns/1ps
module ssm_slave_model (
    input  wire        hclk,
    input  wire        clear,
    input  wire        shift_clock_pin_o,
    input  wire        shift_clock_pin_oe,
    input  wire        serial_data_pin_o,
    input  wire        serial_data_pin_oe,
    output wire        clk_wire,
    output wire        data_wire,
    output reg  [15:0] rx_word,
    output reg  [4:0]  rx_cnt
);
    reg last_bit;
    // slave stays off the data line; released line shows a toggling level
    assign data_wire = serial_data_pin_oe ? serial_data_pin_o : ~last_bit;
    // weak pull-down on the clock line; slave has no clock of its own
    assign clk_wire = shift_clock_pin_oe ? shift_clock_pin_o : 1'b0;
    always @(posedge hclk)
        last_bit <= clear ? 1'b0 : data_wire;
    // sample on the rising (leading) edge, first bit into bit 0
    always @(posedge clk_wire or posedge clear)
        if (clear)
        begin
            rx_word <= 16'h0000;
            rx_cnt  <= 5'h00;
        end
        else
        begin
            rx_word[rx_cnt[3:0]] <= data_wire;
            rx_cnt               <= rx_cnt + 5'h01;
        end
endmodule

//--- tb/ssm_top_bench.sv
// self-checking bench for the serial master transmitter
`timescale 1ns/1ps
`include "ssm_map.vh"
module ssm_top_bench;
    localparam [7:0] TXM = (1<<`SSM_TX_CLKSRC_BIT) | (1<<`SSM_TX_EN_BIT) | (1<<`SSM_TX_SYNC_BIT);
    localparam [7:0] PEN = 1<<`SSM_RX_PORT_BIT;
    logic        hclk, hresetn, hsel, hwrite, slv_clear;
    logic [7:0]  haddr;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [31:0] hwdata, rd;
    wire  [31:0] hrdata;
    wire         hreadyout, hresp, sck_o, sck_oe, sd_o, sd_oe, sck_w, sd_w;
    wire  [15:0] rx_word;
    wire  [4:0]  rx_cnt;
    integer      num_errors, samples_checked;
    ssm_top #(.DIV_WIDTH(8)) dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .shift_clock_pin_o(sck_o), .shift_clock_pin_oe(sck_oe), .shift_clock_pin_i(sck_w),
        .serial_data_pin_o(sd_o), .serial_data_pin_oe(sd_oe), .serial_data_pin_i(sd_w)
    );
    ssm_slave_model u_slave (
        .hclk(hclk), .clear(slv_clear), .shift_clock_pin_o(sck_o),
        .shift_clock_pin_oe(sck_oe), .serial_data_pin_o(sd_o), .serial_data_pin_oe(sd_oe),
        .clk_wire(sck_w), .data_wire(sd_w), .rx_word(rx_word), .rx_cnt(rx_cnt)
    );
    always #25 hclk = ~hclk;
    // ----
    // shared tasks
    // ----
    task end_sim;
        $display("checks %0d errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task timeout;
        num_errors++;
        $display("wait limit used up");
        end_sim();
    endtask
    // a timeout here means the slave never raised its ready within 64 cycles
    task wait_rdy;
        integer i;
        i = 0;
        @(posedge hclk);
        while (hreadyout !== 1'b1)
        begin
            i++;
            if (i > 64)
                timeout();
            @(posedge hclk);
        end
    endtask
    task ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel   <= 1'b1;
        haddr  <= a;
        hwrite <= wr;
        htrans <= 2'b10;
        wait_rdy();
        htrans <= 2'b00;
        hwdata <= d;
        wait_rdy();
        rd = hrdata;
        hsel <= 1'b0;
    endtask
    task wait_bits(input integer n);
        integer i;
        i = 0;
        while (rx_cnt < n)
        begin
            i++;
            if (i > 4000)
                timeout();
            @(posedge hclk);
        end
    endtask
    task wait_empty;
        integer i;
        i = 0;
        ahb(0, `SSM_TX_CTRL_OFS, 0);
        while (rd[`SSM_TX_EMPTY_BIT] !== 1'b1)
        begin
            i++;
            if (i > 300)
                timeout();
            ahb(0, `SSM_TX_CTRL_OFS, 0);
        end
    endtask
    task clr_slave;
        @(posedge hclk);
        slv_clear <= 1'b1;
        @(posedge hclk);
        slv_clear <= 1'b0;
    endtask
    task frame(input logic [7:0] c, input integer n, input logic [15:0] exp);
        clr_slave();
        ahb(1, `SSM_HOLD_OFS, {24'h00_0000, c});
        wait_bits(n);
        wait_empty();
        check("char", rx_word, exp);
        check("clocks", rx_cnt, n);
    endtask
    // ----
    // scenarios
    // ----
    task t_regs;
        ahb(0, `SSM_TX_CTRL_OFS, 0);
        check("tx ctrl", rd, `SSM_TX_CTRL_RST);
        ahb(0, `SSM_RX_CTRL_OFS, 0);
        check("rx ctrl", rd, `SSM_RX_CTRL_RST);
        ahb(1, 8'h10, 32'hffff_ffff);
        ahb(0, 8'h10, 0);
        check("unmapped", rd, 32'h0000_0000);
        check("resp", hresp, 1'b0);
    endtask
    task t_setup;
        ahb(1, `SSM_DIVISOR_OFS, 32'h0000_0003);
        ahb(1, `SSM_TX_CTRL_OFS, {24'h00_0000, TXM});
        check("clk oe off", sck_oe, 1'b0);
        ahb(1, `SSM_RX_CTRL_OFS, {24'h00_0000, PEN});
        #1;
        check("clk oe", sck_oe, 1'b1);
        check("data oe", sd_oe, 1'b1);
    endtask
    task t_single;
        clr_slave();
        ahb(1, `SSM_HOLD_OFS, 32'h0000_00a5);
        @(posedge hclk);
        @(posedge hclk);
        #1;
        check("first bit", sd_o, 1'b1);
        ahb(0, `SSM_TX_CTRL_OFS, 0);
        check("busy", rd[`SSM_TX_EMPTY_BIT], 1'b0);
        wait_bits(8);
        wait_empty();
        check("char", rx_word, 16'h00a5);
        check("clocks", rx_cnt, 8);
    endtask
    task t_back2back;
        clr_slave();
        ahb(1, `SSM_HOLD_OFS, 32'h0000_003c);
        ahb(1, `SSM_HOLD_OFS, 32'h0000_00c3);
        wait_bits(16);
        wait_empty();
        check("two chars", rx_word, 16'hc33c);
        check("clocks", rx_cnt, 16);
    endtask
    task t_nine;
        ahb(1, `SSM_TX_CTRL_OFS, TXM | (1<<`SSM_TX_NINE_BIT) | (1<<`SSM_TX_D9_BIT));
        frame(8'h55, 9, 16'h0155);
        ahb(1, `SSM_TX_CTRL_OFS, {24'h00_0000, TXM});
    endtask
    task t_rxmode;
        ahb(1, `SSM_RX_CTRL_OFS, PEN | (1<<`SSM_RX_SINGLE_BIT));
        #1;
        check("data oe rx", sd_oe, 1'b0);
        ahb(1, `SSM_RX_CTRL_OFS, PEN | (1<<`SSM_RX_CONT_BIT));
        #1;
        check("data oe cont", sd_oe, 1'b0);
        check("clk oe rx", sck_oe, 1'b1);
        ahb(1, `SSM_RX_CTRL_OFS, {24'h00_0000, PEN});
        #1;
        check("data oe tx", sd_oe, 1'b1);
        // clearing the master bit must release the clock pin
        ahb(1, `SSM_TX_CTRL_OFS, TXM & ~(1<<`SSM_TX_CLKSRC_BIT));
        #1;
        check("clk oe slave", sck_oe, 1'b0);
        ahb(1, `SSM_TX_CTRL_OFS, TXM & ~(1<<`SSM_TX_SYNC_BIT));
        #1;
        check("data oe async", sd_oe, 1'b0);
        ahb(1, `SSM_TX_CTRL_OFS, {24'h00_0000, TXM});
        #1;
        check("data oe back", sd_oe, 1'b1);
    endtask
    task t_transmit_en;
        clr_slave();
        ahb(1, `SSM_TX_CTRL_OFS, TXM & ~(1<<`SSM_TX_EN_BIT));
        ahb(1, `SSM_HOLD_OFS, 32'h0000_000f);
        repeat (40) @(posedge hclk);
        check("held", rx_cnt, 0);
        ahb(1, `SSM_TX_CTRL_OFS, {24'h00_0000, TXM});
        wait_bits(8);
        wait_empty();
        check("released", rx_word, 16'h000f);
    endtask
    task t_abort;
        clr_slave();
        ahb(1, `SSM_HOLD_OFS, 32'h0000_00ff);
        wait_bits(3);
        ahb(1, `SSM_RX_CTRL_OFS, 0);
        @(posedge hclk);
        #1;
        check("clk oe", sck_oe, 1'b0);
        check("clk low", sck_o, 1'b0);
        ahb(1, `SSM_RX_CTRL_OFS, {24'h00_0000, PEN});
        repeat (40) @(posedge hclk);
        wait_empty();
        check("no resume", rx_cnt, 3);
    endtask
    initial
    begin
        hclk = 0;
        hresetn = 0;
        hsel = 0;
        haddr = 0;
        htrans = 0;
        hwrite = 0;
        hsize = 3'b010;
        hwdata = 0;
        slv_clear = 1;
        num_errors = 0;
        samples_checked = 0;
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        slv_clear <= 1'b0;
        t_regs();
        t_setup();
        t_single();
        t_back2back();
        t_nine();
        t_rxmode();
        t_transmit_en();
        t_abort();
        end_sim();
    end
endmodule
